// >>> core/cfc_flow_ctrl.sv
/*
 * condition evaluation and program-flow control of the core pipeline.
 * assumes the decoder holds an instruction while stall_decode is high,
 * an external stack served by push_req/pop_req, and a one-clock core.
 */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cfc_flow_ctrl import cfc_pkg::*; (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	input  wire cfc_instr_t        instr,
	input  wire logic [ACC_W-1:0]  acc_value,
	input  wire logic              carry_flag,
	input  wire logic              test_flag,
	input  wire logic              wrap_event,
	input  wire logic              branch_input_pin_b,
	input  wire logic [PC_W-1:0]   ret_addr,
	input  wire logic [PC_W-1:0]   stack_top,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	output logic                   stall_decode,
	output logic                   flush,
	output logic                   pc_load,
	output logic [PC_W-1:0]        pc_target,
	output logic                   push_req,
	output logic [PC_W-1:0]        push_addr,
	output logic                   pop_req,
	output logic                   nop_sub,
	output logic                   int_allow,
	output logic                   arith_wrap_flag,
	output logic                   cond_result
);
	cfc_state_t      state;
	cfc_state_t      next_state;
	logic [1:0]      cnt;
	logic [1:0]      slot_left;
	logic [1:0]      xc_left;
	cfc_op_t         op_q;
	cfc_cond_t       cond_q;
	logic [PC_W-1:0] target_q;
	logic [PC_W-1:0] ret_q;
	logic            taken_q;
	logic            irq_gate;
	logic            pin_s1;
	logic            pin_s2;
	logic            pin_s3;
	logic            pin_low;
	cfc_flags_t      flags_live;
	cfc_flags_t      flags_prev;
	cfc_flags_t      eval_flags;
	cfc_cond_t       eval_cond;
	logic            eval_res;
	logic            dec_ok;
	logic            dispatch;
	logic            is_exec;
	logic            is_delayed;
	logic [1:0]      words;
	logic            slot_done;
	logic            wrap_clr;

	// pin synchroniser, level accepted once second and third stages agree
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			pin_s3 <= 1'b1;
			pin_low <= 1'b0;
		end else if (clk_en) begin
			pin_s1 <= branch_input_pin_b;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) begin
				pin_low <= !pin_s3;
			end
		end
	end

	always_comb begin
		flags_live.acc_zero     = (acc_value == '0);
		flags_live.acc_negative = acc_value[ACC_W-1];
		flags_live.carry        = carry_flag;
		flags_live.test_flag    = test_flag;
		flags_live.wrap         = arith_wrap_flag;
		flags_live.pin_low      = pin_low;
	end

	// flag picture one cycle old for conditional execute
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_prev <= '0;
		end else if (clk_en) begin
			flags_prev <= flags_live;
		end
	end

	assign dec_ok     = instr.valid && !stall_decode;
	assign words      = instr.two_words ? 2'h2 : 2'h1;
	assign is_exec    = (instr.op == OP_EXEC_IF1) || (instr.op == OP_EXEC_IF2);
	assign is_delayed = (instr.op == OP_BRANCH_IF_DELAYED) || (instr.op == OP_CALL_IF_DELAYED)
		|| (instr.op == OP_COND_EXIT_DELAYED);
	// suppressed words never dispatch, even when they encode a branch
	assign dispatch   = dec_ok && (state == ST_IDLE) && !(xc_left != 2'h0 && nop_sub)
		&& (xc_left == 2'h0) && (instr.op != OP_OTHER);
	assign slot_done  = (state == ST_SLOT) && dec_ok && (words >= slot_left);

	always_comb begin
		if (state == ST_BR_WAIT) begin
			eval_cond  = cond_q;
			eval_flags = flags_live;
		end else begin
			eval_cond  = instr.cond;
			eval_flags = is_exec ? flags_prev : flags_live;
		end
	end

	cfc_cond_eval u_eval (
		.cond   (eval_cond),
		.flags  (eval_flags),
		.result (eval_res)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (dispatch && !is_exec) begin
					next_state = is_delayed ? ST_SLOT : ST_BR_WAIT;
				end
			end
			ST_BR_WAIT: begin
				if (cnt == 2'h0) begin
					next_state = eval_res ? ST_FLUSH : ST_IDLE;
				end
			end
			ST_FLUSH: begin
				if (cnt == 2'h0) begin
					next_state = ST_IDLE;
				end
			end
			ST_SLOT: begin
				if (slot_done) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// wait and flush counter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 2'h0;
		end else if (clk_en) begin
			if (state == ST_IDLE) begin
				cnt <= BR_WAIT_CYC - 2'h1;
			end else if (state == ST_BR_WAIT && cnt == 2'h0) begin
				cnt <= FLUSH_CYC - 2'h1;
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
		end
	end

	// decode-time capture of the conditional instruction
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_q     <= OP_OTHER;
			cond_q   <= '0;
			target_q <= '0;
			ret_q    <= '0;
			taken_q  <= 1'b0;
		end else if (clk_en && dispatch && !is_exec) begin
			op_q     <= instr.op;
			cond_q   <= instr.cond;
			target_q <= instr.target;
			ret_q    <= is_delayed ? ret_addr + {{(PC_W-2){1'b0}}, DELAY_WORDS} : ret_addr;
			taken_q  <= eval_res;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_left <= 2'h0;
		end else if (clk_en) begin
			if (dispatch && is_delayed) begin
				slot_left <= DELAY_WORDS;
			end else if (state == ST_SLOT && dec_ok) begin
				slot_left <= slot_done ? 2'h0 : slot_left - words;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stall_decode <= 1'b0;
		end else if (clk_en) begin
			stall_decode <= (next_state == ST_BR_WAIT) || (next_state == ST_FLUSH);
		end
	end

	// transfer of control: plain forms after evaluation, delayed after slots
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_load   <= 1'b0;
			flush     <= 1'b0;
			pc_target <= '0;
			push_req  <= 1'b0;
			push_addr <= '0;
			pop_req   <= 1'b0;
		end else if (clk_en) begin
			pc_load  <= 1'b0;
			flush    <= 1'b0;
			push_req <= 1'b0;
			pop_req  <= 1'b0;
			if (state == ST_BR_WAIT && cnt == 2'h0 && eval_res) begin
				pc_load   <= 1'b1;
				flush     <= 1'b1;
				pc_target <= (op_q == OP_COND_EXIT) ? stack_top : target_q;
				pop_req   <= (op_q == OP_COND_EXIT);
				push_req  <= (op_q == OP_CALL_IF);
				push_addr <= ret_q;
			end else if (slot_done && taken_q) begin
				pc_load   <= 1'b1;
				pc_target <= (op_q == OP_COND_EXIT_DELAYED) ? stack_top : target_q;
				pop_req   <= (op_q == OP_COND_EXIT_DELAYED);
				push_req  <= (op_q == OP_CALL_IF_DELAYED);
				push_addr <= ret_q;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cond_result <= 1'b0;
		end else if (clk_en && (dispatch || (state == ST_BR_WAIT && cnt == 2'h0))) begin
			cond_result <= eval_res;
		end
	end

	// conditional execute: governed words pass, replaced by nop on a failed test
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			xc_left <= 2'h0;
			nop_sub <= 1'b0;
		end else if (clk_en) begin
			if (dispatch && is_exec) begin
				xc_left <= (instr.op == OP_EXEC_IF2) ? XC2_WORDS : XC1_WORDS;
				nop_sub <= !eval_res;
			end else if (xc_left != 2'h0 && dec_ok) begin
				if (words >= xc_left) begin
					xc_left <= 2'h0;
					nop_sub <= 1'b0;
				end else begin
					xc_left <= xc_left - words;
				end
			end
		end
	end

	// interrupts only between whole flow sequences, so also just before exec_if
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			int_allow <= 1'b1;
		end else if (clk_en) begin
			int_allow <= !irq_gate || ((next_state == ST_IDLE) && !(dispatch && is_exec)
				&& !(xc_left != 2'h0 && !(dec_ok && words >= xc_left)));
		end
	end

	// branch clears only once the wrap test has been evaluated, plain form at its decision edge
	assign wrap_clr = (dispatch && instr.op == OP_BRANCH_IF_DELAYED && instr.cond.ov != OVS_NONE)
		|| (state == ST_BR_WAIT && cnt == 2'h0 && op_q == OP_BRANCH_IF && cond_q.ov != OVS_NONE)
		|| (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_WRAP_CLR_BIT]);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			arith_wrap_flag <= 1'b0;
		end else if (clk_en) begin
			if (wrap_event) begin
				arith_wrap_flag <= 1'b1;
			end else if (wrap_clr) begin
				arith_wrap_flag <= 1'b0;
			end
		end
	end

	// register port
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_gate <= CTRL_IRQ_GATE_RST;
		end else if (clk_en && reg_wr && reg_addr == REG_CTRL) begin
			irq_gate <= reg_wdata[CTRL_IRQ_GATE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_rd && reg_addr == REG_CTRL) begin
				reg_rdata[CTRL_IRQ_GATE_BIT] <= irq_gate;
			end else if (reg_rd && reg_addr == REG_STATUS) begin
				reg_rdata[STAT_WRAP_BIT]  <= arith_wrap_flag;
				reg_rdata[STAT_COND_BIT]  <= cond_result;
				reg_rdata[STAT_NOP_BIT]   <= nop_sub;
				reg_rdata[STAT_BUSY_BIT]  <= (state != ST_IDLE) || (xc_left != 2'h0);
				reg_rdata[STAT_STALL_BIT] <= stall_decode;
			end
		end
	end

	// checks
	wrap_set_held_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && wrap_event |=> arith_wrap_flag)
		else $error("wrap event not latched");

	taken_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && state == ST_BR_WAIT && cnt == 2'h0 && eval_res |=> pc_load && flush && stall_decode)
		else $error("taken branch did not load and flush");

	untaken_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && state == ST_BR_WAIT && cnt == 2'h0 && !eval_res |=> !stall_decode && !pc_load)
		else $error("untaken branch kept decode stalled");

	branch_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && dispatch && !is_exec && !is_delayed |=> stall_decode && state == ST_BR_WAIT)
		else $error("plain branch did not stall decode");

	call_push_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		pc_load && (op_q == OP_CALL_IF || op_q == OP_CALL_IF_DELAYED) |-> push_req && push_addr == ret_q)
		else $error("taken call did not push return address");

	delayed_noflush_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && slot_done && taken_q |=> pc_load && !flush && !stall_decode)
		else $error("delayed transfer flushed or stalled");

	slot_frozen_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state == ST_SLOT && $past(state) == ST_SLOT |-> $stable(taken_q))
		else $error("delayed decision changed inside slots");

	exec_nop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && dispatch && is_exec |=> nop_sub == !$past(eval_res) && xc_left != 2'h0)
		else $error("exec_if squash does not follow its test");

	exec_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && nop_sub && xc_left == 2'h2 && dec_ok && !instr.two_words |=> nop_sub)
		else $error("second governed word not replaced");

	pin_agree_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && pin_s2 != pin_s3 |=> $stable(pin_low))
		else $error("pin level taken before stages agree");
endmodule
`default_nettype wire

// >>> core/cfc_pkg.sv
/*
 * shared types and constants of the condition and flow control block.
 * assumes a decode stage that presents one instruction per cycle with its
 * condition operands already split by group, and a stack outside the block.
 */
// Function
// - accumulator zero, nonzero, sign tests against zero
// - carry, wrap, test flag, pin low, always
// - conditional flow ops evaluate before transferring control
// - several conditions: all must hold
// - at most four conditions, one per group
// - groups: accumulator, wrap, carry, test/pin
// - plain branch stalls decode until flags valid
// - taken: load target, flush, four cycles
// - untaken: next instruction decodes, two cycles
// - call also pushes the return address
// - conditional exit costs same as branch
// - delayed forms run two slot words, no flush
// - two-word slot instruction alone fills slots
// - delayed forms use flags before slot code
// - exec_if governs one or two words
// - failed exec_if substitutes no-operation
// - exec_if uses flags one cycle old
// - interrupt allowed just before exec_if
// - wrap flag sticky, cleared by wrap-testing branch
package cfc_pkg;

	localparam int PC_W   = 16;
	localparam int ACC_W  = 32;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

	localparam int CTRL_IRQ_GATE_BIT = 0;
	localparam int CTRL_WRAP_CLR_BIT = 1;
	localparam logic CTRL_IRQ_GATE_RST = 1'b1;

	localparam int STAT_WRAP_BIT  = 0;
	localparam int STAT_COND_BIT  = 1;
	localparam int STAT_NOP_BIT   = 2;
	localparam int STAT_BUSY_BIT  = 3;
	localparam int STAT_STALL_BIT = 4;

	localparam logic [1:0] BR_WAIT_CYC = 2'h1;
	localparam logic [1:0] FLUSH_CYC   = 2'h2;
	localparam logic [1:0] DELAY_WORDS = 2'h2;
	localparam logic [1:0] XC1_WORDS   = 2'h1;
	localparam logic [1:0] XC2_WORDS   = 2'h2;

	typedef enum logic [2:0] {
		ACC_NONE, ACC_ZERO, ACC_NONZERO, ACC_NEGATIVE,
		ACC_NONPOSITIVE, ACC_POSITIVE, ACC_NONNEGATIVE
	} cfc_acc_t;

	typedef enum logic [1:0] {OVS_NONE, OVS_WRAP, OVS_NO_WRAP} cfc_ovs_t;
	typedef enum logic [1:0] {CYS_NONE, CYS_CLEAR, CYS_SET} cfc_cys_t;
	typedef enum logic [1:0] {TBS_NONE, TBS_FLAG_SET, TBS_FLAG_CLEAR, TBS_PIN_LOW} cfc_tbs_t;

	typedef enum logic [3:0] {
		OP_OTHER, OP_BRANCH_IF, OP_BRANCH_IF_DELAYED, OP_CALL_IF, OP_CALL_IF_DELAYED,
		OP_COND_EXIT, OP_COND_EXIT_DELAYED, OP_EXEC_IF1, OP_EXEC_IF2
	} cfc_op_t;

	typedef enum {ST_IDLE, ST_BR_WAIT, ST_FLUSH, ST_SLOT} cfc_state_t;

	typedef struct packed {
		cfc_acc_t acc;
		cfc_ovs_t ov;
		cfc_cys_t cy;
		cfc_tbs_t tb;
	} cfc_cond_t;

	typedef struct packed {
		logic            valid;
		cfc_op_t         op;
		logic            two_words;
		cfc_cond_t       cond;
		logic [PC_W-1:0] target;
	} cfc_instr_t;

	typedef struct packed {
		logic acc_zero;
		logic acc_negative;
		logic carry;
		logic test_flag;
		logic wrap;
		logic pin_low;
	} cfc_flags_t;

endpackage

// >>> core/cfc_cond_eval.sv
/*
 * combinational condition test: one selector per group, all must hold.
 * assumes flags are already settled and synchronised by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module cfc_cond_eval import cfc_pkg::*; (
	input  wire cfc_cond_t  cond,
	input  wire cfc_flags_t flags,
	output logic            result
);
	logic acc_ok;
	logic ov_ok;
	logic cy_ok;
	logic tb_ok;

	always_comb begin
		unique case (cond.acc)
			ACC_ZERO:        acc_ok = flags.acc_zero;
			ACC_NONZERO:     acc_ok = !flags.acc_zero;
			ACC_NEGATIVE:    acc_ok = flags.acc_negative;
			ACC_NONPOSITIVE: acc_ok = flags.acc_negative || flags.acc_zero;
			ACC_POSITIVE:    acc_ok = !flags.acc_negative && !flags.acc_zero;
			ACC_NONNEGATIVE: acc_ok = !flags.acc_negative;
			default:         acc_ok = 1'b1;
		endcase
		unique case (cond.ov)
			OVS_WRAP:    ov_ok = flags.wrap;
			OVS_NO_WRAP: ov_ok = !flags.wrap;
			default:     ov_ok = 1'b1;
		endcase
		unique case (cond.cy)
			CYS_CLEAR: cy_ok = !flags.carry;
			CYS_SET:   cy_ok = flags.carry;
			default:   cy_ok = 1'b1;
		endcase
		unique case (cond.tb)
			TBS_FLAG_SET:   tb_ok = flags.test_flag;
			TBS_FLAG_CLEAR: tb_ok = !flags.test_flag;
			TBS_PIN_LOW:    tb_ok = flags.pin_low;
			default:        tb_ok = 1'b1;
		endcase
	end

	// one field per group, so two tests of one group cannot be encoded
	assign result = acc_ok && ov_ok && cy_ok && tb_ok;
endmodule
`default_nettype wire

// >>> dv/cfc_imem_model.sv
/*
 * program memory model: presents queued instruction words in order.
 * assumes the flow block raises stall_decode to hold the current word.
 */
`timescale 1ns/1ps
`default_nettype none
module cfc_imem_model import cfc_pkg::*; (
	input  wire logic     sys_clk,
	input  wire logic     rst_b,
	input  wire logic     clk_en,
	input  wire logic     stall_decode,
	output var cfc_instr_t instr
);
	cfc_instr_t q[$];
	cfc_instr_t idle_w;

	task automatic put(input cfc_instr_t w);
		q.push_back(w);
	endtask

	// next word only once the held one is taken; idle words show a moving pattern
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			instr <= '0;
		end else if (!instr.valid || (!stall_decode && clk_en)) begin
			idle_w = ~instr;
			idle_w.valid = 1'b0;
			instr <= (q.size() > 0) ? q.pop_front() : idle_w;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/*
 * self-checking bench of the flow control block against a behavioural model.
 * assumes cfc_pkg, the design and the program memory model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top import cfc_pkg::*;;
	logic              sys_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              clk_en = 1'b1;
	logic [ACC_W-1:0]  acc_value = '0;
	logic              carry_flag = 1'b0, test_flag = 1'b0, wrap_event = 1'b0, pin_b = 1'b1;
	logic [PC_W-1:0]   ret_addr = '0, stack_top = '0, pc_target, push_addr;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
	logic              reg_wr = 1'b0, reg_rd = 1'b0;
	logic              stall_decode, flush, pc_load, push_req, pop_req, nop_sub, int_allow;
	logic              arith_wrap_flag, cond_result;
	cfc_instr_t        pm_instr;
	int                fails = 0, n_compared = 0, cyc = 0;
	bit                m_wrap = 0, m_res = 0, gate = 1;

	always #10 sys_clk = ~sys_clk;

	cfc_imem_model pm (.sys_clk, .rst_b, .clk_en, .stall_decode, .instr(pm_instr));

	cfc_flow_ctrl dut (.sys_clk, .rst_b, .clk_en, .instr(pm_instr), .acc_value, .carry_flag, .test_flag,
		.wrap_event, .branch_input_pin_b(pin_b), .ret_addr, .stack_top, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .stall_decode, .flush, .pc_load, .pc_target, .push_req, .push_addr, .pop_req,
		.nop_sub, .int_allow, .arith_wrap_flag, .cond_result);

	task automatic stop_test;
		if (fails == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk_b(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t flag got %b want %b", $time, g, e);
		end
	endtask

	task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t word got %h want %h", $time, g, e);
		end
	endtask

	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk_w(reg_rdata, e);
		step();
		chk_w(reg_rdata, 16'h0000);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	function automatic bit m_cond(input cfc_cond_t c, input bit cy);
		int a;
		bit r;
		a = $signed(acc_value);
		r = 1'b1;
		case (c.acc)
			ACC_ZERO: r &= a == 0;
			ACC_NONZERO: r &= a != 0;
			ACC_NEGATIVE: r &= a < 0;
			ACC_NONPOSITIVE: r &= a <= 0;
			ACC_POSITIVE: r &= a > 0;
			ACC_NONNEGATIVE: r &= a >= 0;
			default: ;
		endcase
		if (c.ov != OVS_NONE) r &= m_wrap == (c.ov == OVS_WRAP);
		if (c.cy != CYS_NONE) r &= cy == (c.cy == CYS_SET);
		case (c.tb)
			TBS_FLAG_SET: r &= test_flag;
			TBS_FLAG_CLEAR: r &= !test_flag;
			TBS_PIN_LOW: r &= !pin_b;
			default: ;
		endcase
		return r;
	endfunction

	function automatic cfc_instr_t mk(input cfc_op_t op, input cfc_cond_t c, input bit tw);
		return '{valid: 1'b1, op: op, two_words: tw, cond: c, target: 16'($urandom)};
	endfunction

	task automatic rnd_flags;
		int k;
		k = $urandom_range(0, 2);
		@(posedge sys_clk);
		acc_value <= (k == 0) ? '0 : (k == 1) ? ACC_W'($urandom_range(1, 999)) : -ACC_W'($urandom_range(1, 999));
		carry_flag <= 1'($urandom);
		test_flag <= 1'($urandom);
		pin_b <= 1'($urandom);
		ret_addr <= 16'($urandom);
		stack_top <= 16'($urandom);
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_disp;
		int k;
		for (k = 0; k < 20; k++) begin
			@(posedge sys_clk);
			if (pm_instr.valid === 1'b1 && stall_decode === 1'b0) break;
		end
		if (k == 20) begin
			fails++;
			$display("[ERR] %0t conditional word never dispatched", $time);
		end
		#1;
	endtask

	task automatic run_plain(input cfc_instr_t w);
		bit tk;
		tk = m_cond(w.cond, carry_flag);
		m_res = tk;
		if (w.op == OP_BRANCH_IF && w.cond.ov != OVS_NONE) m_wrap = 0;
		pm.put(w);
		wait_disp();
		chk_b(stall_decode, 1'b1);
		chk_b(int_allow, !gate);
		step();
		chk_b(pc_load, tk);
		chk_b(flush, tk);
		chk_b(push_req, tk && w.op == OP_CALL_IF);
		chk_b(pop_req, tk && w.op == OP_COND_EXIT);
		chk_b(stall_decode, tk);
		chk_b(cond_result, tk);
		if (tk) chk_w(pc_target, (w.op == OP_COND_EXIT) ? stack_top : w.target);
		if (tk && w.op == OP_CALL_IF) chk_w(push_addr, ret_addr);
		step();
		chk_b(stall_decode, tk);
		step();
		chk_b(stall_decode, 1'b0);
	endtask

	task automatic run_del(input cfc_instr_t w, input bit two);
		bit tk;
		int j;
		int n;
		tk = m_cond(w.cond, carry_flag);
		m_res = tk;
		if (w.op == OP_BRANCH_IF_DELAYED && w.cond.ov != OVS_NONE) m_wrap = 0;
		n = two ? 1 : 2;
		pm.put(w);
		pm.put(mk(OP_OTHER, '0, two));
		if (!two) pm.put(mk(OP_OTHER, '0, 1'b0));
		wait_disp();
		carry_flag <= !carry_flag;
		test_flag <= !test_flag;
		acc_value <= ~acc_value;
		for (j = 0; j <= n; j++) begin
			if (j > 0) step();
			chk_b(pc_load, j == n && tk);
			chk_b(flush, 1'b0);
			chk_b(stall_decode, 1'b0);
		end
		chk_b(push_req, tk && w.op == OP_CALL_IF_DELAYED);
		chk_b(pop_req, tk && w.op == OP_COND_EXIT_DELAYED);
		if (tk) chk_w(pc_target, (w.op == OP_COND_EXIT_DELAYED) ? stack_top : w.target);
		if (tk && w.op == OP_CALL_IF_DELAYED) chk_w(push_addr, ret_addr + 16'h0002);
	endtask

	task automatic run_xc(input bit [2:0] k);
		int j;
		int n;
		n = (k[0] && !k[1]) ? 2 : 1;
		@(posedge sys_clk);
		carry_flag <= k[2];
		repeat (2) @(posedge sys_clk);
		#1;
		pm.put(mk(k[0] ? OP_EXEC_IF2 : OP_EXEC_IF1, '{ACC_NONE, OVS_NONE, CYS_SET, TBS_NONE}, 1'b0));
		pm.put(mk(OP_OTHER, '0, k[1]));
		if (n == 2) pm.put(mk(OP_OTHER, '0, 1'b0));
		@(posedge sys_clk);
		carry_flag <= !k[2];
		#1 chk_b(int_allow, 1'b1);
		wait_disp();
		chk_b(cond_result, k[2]);
		m_res = k[2];
		for (j = 1; j <= n + 1; j++) begin
			chk_b(nop_sub, j <= n && !k[2]);
			step();
		end
	endtask

	task automatic wrap_pulse;
		@(posedge sys_clk);
		wrap_event <= 1'b1;
		acc_value <= 32'h0000_0001;
		@(posedge sys_clk);
		wrap_event <= 1'b0;
		m_wrap = 1;
		#1 chk_b(arith_wrap_flag, 1'b1);
	endtask

	initial begin
		int i;
		cfc_cond_t c;
		cfc_op_t op;
		void'($urandom(32'h5106));
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		step();
		chk_b(int_allow, 1'b1);
		chk_b(pc_load, 1'b0);
		rd(REG_CTRL, 16'h0001);
		rd(REG_STATUS, 16'h0000);
		rd(4'hF, 16'h0000);
		wr(4'hF, 16'hFFFF);
		rd(REG_CTRL, 16'h0001);
		for (i = 0; i < 30; i++) begin
			if (i == 15) begin
				wr(REG_CTRL, 16'h0000);
				gate = 0;
			end
			rnd_flags();
			c = '{cfc_acc_t'($urandom_range(0, 6)), cfc_ovs_t'($urandom_range(0, 2)),
				cfc_cys_t'($urandom_range(0, 2)), cfc_tbs_t'($urandom_range(0, 3))};
			if (i < 2) c = '0;
			op = (i % 3 == 0) ? OP_BRANCH_IF : (i % 3 == 1) ? OP_CALL_IF : OP_COND_EXIT;
			if (i % 6 < 3) run_plain(mk(op, c, 1'b1));
			else run_del(mk(cfc_op_t'(op + 1), c, 1'b1), 1'($urandom));
		end
		wr(REG_CTRL, 16'h0001);
		gate = 1;
		for (i = 0; i < 8; i++) run_xc(3'(i));
		wrap_pulse();
		rd(REG_STATUS, {14'h0, m_res, m_wrap});
		run_plain(mk(OP_CALL_IF, '{ACC_NONE, OVS_WRAP, CYS_NONE, TBS_NONE}, 1'b1));
		chk_b(arith_wrap_flag, 1'b1);
		run_plain(mk(OP_BRANCH_IF, '{ACC_NONZERO, OVS_WRAP, CYS_NONE, TBS_NONE}, 1'b1));
		chk_b(arith_wrap_flag, 1'b0);
		wrap_pulse();
		wr(REG_CTRL, 16'h0003);
		step();
		chk_b(arith_wrap_flag, 1'b0);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wrap_event <= 1'b1;
		@(posedge sys_clk);
		wrap_event <= 1'b0;
		clk_en <= 1'b1;
		#1 chk_b(arith_wrap_flag, 1'b0);
		wrap_pulse();
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		step();
		chk_b(arith_wrap_flag, 1'b0);
		chk_b(int_allow, 1'b1);
		chk_b(stall_decode, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
